// ==== shared/pitcm_map.svh ====
// Port addresses, field positions, reset values and timing counts of the interval timer
`ifndef PITCM_MAP_SVH
`define PITCM_MAP_SVH
`define PITCM_PORT_COUNT0  16'h0040
`define PITCM_PORT_COUNT1  16'h0041
`define PITCM_PORT_COUNT2  16'h0042
`define PITCM_PORT_CTRL    16'h0043
`define PITCM_PORT_SYSB    16'h0061
`define PITCM_SEL_HI       7
`define PITCM_SEL_LO       6
`define PITCM_RW_HI        5
`define PITCM_RW_LO        4
`define PITCM_MODE_HI      3
`define PITCM_MODE_LO      1
`define PITCM_BCD_BIT      0
`define PITCM_RB_LATCH_COUNT_N   5
`define PITCM_RB_LATCH_STATUS_N  4
`define PITCM_RB_SEL0      1
`define PITCM_SYSB_GATE    0
`define PITCM_SYSB_OUT2    5
`define PITCM_SEL_RDBK     2'h3
`define PITCM_RW_LATCH     2'h0
`define PITCM_RW_LSB       2'h1
`define PITCM_RW_MSB       2'h2
`define PITCM_RW_BOTH      2'h3
`define PITCM_MODE0        3'h0
`define PITCM_MODE1        3'h1
`define PITCM_MODE2        3'h2
`define PITCM_MODE3        3'h3
`define PITCM_MODE4        3'h4
`define PITCM_MODE5        3'h5
`define PITCM_MODE2_ALIAS  3'h6
`define PITCM_MODE3_ALIAS  3'h7
`define PITCM_CMD_RST      8'h00
`define PITCM_CTRL_RD_VAL  8'h00
`define PITCM_CNT_RST      16'h0000
`define PITCM_CLK_NS       8
`define PITCM_TICK_NS      838
`define PITCM_TICK_CYC     (`PITCM_TICK_NS / `PITCM_CLK_NS)
`endif

// ==== shared/pitcm_pkg.sv ====
// Types shared by the interval timer modules
package pitcm_pkg;
	typedef logic [2:0]  pitcm_mode_t;
	typedef logic [1:0]  pitcm_rw_t;
	typedef logic [15:0] pitcm_count_t;
	typedef enum logic [1:0] {cmd_none, cmd_mode, cmd_latch, cmd_rdbk} pitcm_cmd_t;
endpackage

// ==== hw/pitcm_channel.sv ====
// One counting channel: counting element, six modes, output and null count
`include "pitcm_map.svh"
module pitcm_channel import pitcm_pkg::*; #(
	parameter bit HAS_GATE = 1'b1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset,
	// Count tick and gate
	input  wire logic         tick,
	input  wire logic         gate,
	// Programming
	input  wire logic         mode_wr,
	input  wire pitcm_mode_t  mode_in,
	input  wire logic         bcd_in,
	input  wire logic         load,
	input  wire pitcm_count_t load_val,
	// State
	output pitcm_count_t      count_ff,
	output logic              out_ff,
	output logic              null_ff
);
	pitcm_mode_t  mode_ff;
	pitcm_mode_t  nxt_mode;
	logic         bcd_ff;
	pitcm_count_t init_ff;
	logic         pend_ff;
	logic         run_ff;
	logic         gate_d_ff;
	logic         trig_ff;
	logic         hw_trig;
	logic         start;

	function automatic pitcm_count_t dec(input pitcm_count_t v, input logic b);
		pitcm_count_t r;
		logic         borrow;
		r = v - 16'h0001;
		borrow = 1'b1;
		if (b) begin
			r = v;
			for (int i = 0; i < 4; i++) begin
				if (borrow) begin
					if (v[i*4 +: 4] == 4'h0) begin
						r[i*4 +: 4] = 4'h9;
					end else begin
						r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	always_comb begin
		nxt_mode = mode_in;
		if (mode_in == `PITCM_MODE2_ALIAS) begin
			nxt_mode = `PITCM_MODE2;
		end else if (mode_in == `PITCM_MODE3_ALIAS) begin
			nxt_mode = `PITCM_MODE3;
		end
	end

	assign hw_trig = (mode_ff == `PITCM_MODE1) || (mode_ff == `PITCM_MODE5);
	// Periodic modes pick up a new count only at their own reload
	assign start = hw_trig ? trig_ff :
		(pend_ff && !(run_ff && (mode_ff == `PITCM_MODE2 || mode_ff == `PITCM_MODE3)));

	// Gate edge is caught on the fast clock and consumed on the next tick
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gate_d_ff <= 1'b0;
			trig_ff <= 1'b0;
		end else begin
			gate_d_ff <= gate;
			if (HAS_GATE && gate && !gate_d_ff) begin
				trig_ff <= 1'b1;
			end else if (tick) begin
				trig_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_ff <= `PITCM_MODE0;
			bcd_ff <= 1'b0;
			init_ff <= `PITCM_CNT_RST;
			count_ff <= `PITCM_CNT_RST;
			out_ff <= 1'b1;
			null_ff <= 1'b0;
			pend_ff <= 1'b0;
			run_ff <= 1'b0;
		end else if (mode_wr) begin
			mode_ff <= nxt_mode;
			bcd_ff <= bcd_in;
			out_ff <= (nxt_mode != `PITCM_MODE0);
			pend_ff <= 1'b0;
			run_ff <= 1'b0;
			null_ff <= 1'b1;
		end else if (load) begin
			init_ff <= load_val;
			pend_ff <= 1'b1;
			null_ff <= 1'b1;
			if (mode_ff == `PITCM_MODE0) begin
				out_ff <= 1'b0;
			end
		end else if (tick) begin
			if (start) begin
				count_ff <= init_ff;
				pend_ff <= 1'b0;
				null_ff <= 1'b0;
				run_ff <= 1'b1;
				out_ff <= (mode_ff != `PITCM_MODE1) && (mode_ff != `PITCM_MODE0);
			end else if (run_ff && (hw_trig || gate)) begin
				count_ff <= dec(count_ff, bcd_ff);
				case (mode_ff)
					`PITCM_MODE0: begin
						if (count_ff == 16'h0001) out_ff <= 1'b1;
					end
					`PITCM_MODE1: begin
						if (count_ff == 16'h0001) begin
							out_ff <= 1'b1;
							run_ff <= 1'b0;
						end
					end
					`PITCM_MODE2: begin
						if (count_ff == 16'h0002) begin
							out_ff <= 1'b0;
						end else if (count_ff == 16'h0001) begin
							count_ff <= init_ff;
							out_ff <= 1'b1;
							pend_ff <= 1'b0;
							null_ff <= 1'b0;
						end
					end
					`PITCM_MODE3: begin
						// Half point is taken in binary even for decimal counts
						if (count_ff == 16'h0001) begin
							count_ff <= init_ff;
							out_ff <= 1'b1;
							pend_ff <= 1'b0;
							null_ff <= 1'b0;
						end else if (dec(count_ff, bcd_ff) == (init_ff >> 1)) begin
							out_ff <= 1'b0;
						end
					end
					default: begin
						if (!out_ff) begin
							out_ff <= 1'b1;
							run_ff <= 1'b0;
						end else if (count_ff == 16'h0001) begin
							out_ff <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	mode_out_init_a: assert property (mode_wr |=> out_ff == (mode_ff != `PITCM_MODE0))
		else $error("output not at mode start level");
	mode0_hold_a: assert property ((mode_ff == `PITCM_MODE0) && out_ff && !mode_wr && !load |=> out_ff)
		else $error("mode 0 output dropped without new count");
	oneshot_fire_a: assert property ((mode_ff == `PITCM_MODE1) && tick && trig_ff && !mode_wr && !load
		|=> !out_ff)
		else $error("mode 1 trigger did not drive output low");
	rate_pulse_a: assert property ((mode_ff == `PITCM_MODE2) && run_ff && !out_ff && tick && !mode_wr && !load
		|=> out_ff)
		else $error("mode 2 low pulse longer than one tick");
	strobe_end_a: assert property ((mode_ff == `PITCM_MODE4) && !out_ff && tick && !mode_wr && !load
		|=> out_ff)
		else $error("strobe longer than one tick");
	null_set_a: assert property (load && !mode_wr |=> null_ff)
		else $error("null count not set by count write");
endmodule

// ==== hw/pitcm_top.sv ====
// Interval timer: command port decode, latch and read-back, count ports, channel 2 gate
`include "pitcm_map.svh"
module pitcm_top import pitcm_pkg::*; #(
	parameter int CHANNELS = 3,
	parameter int TICK_DIV = `PITCM_TICK_CYC
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// I/O cycles from the host
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic [7:0]       io_rdata,
	// Pins
	input  wire logic        channel2_gate_pin,
	output logic [2:0]       timer_out
);
	logic [7:0]   io_rdata_ff;
	logic [15:0]  div_ff;
	logic         tick_ff;
	logic         soft_gate_ff;
	logic         gate2_ff;
	pitcm_cmd_t   cmd;
	logic         wr_ctrl;
	logic [2:0]   mode_wr;
	logic [2:0]   latch_req;
	logic [2:0]   sta_req;
	logic [2:0]   wr_cnt;
	logic [2:0]   rd_cnt;
	logic [2:0]   load;
	logic [2:0]   gate;
	logic [2:0]   out_w;
	logic [2:0]   null_w;
	pitcm_count_t load_val [3];
	pitcm_count_t cnt      [3];
	pitcm_count_t lat_ff   [3];
	pitcm_rw_t    rw_ff    [3];
	pitcm_mode_t  mode_ff  [3];
	logic [7:0]   sta_ff   [3];
	logic [7:0]   wr_lo_ff [3];
	logic [7:0]   rd_byte  [3];
	logic [2:0]   bcd_ff;
	logic [2:0]   wr_hi_ff;
	logic [2:0]   rd_hi_ff;
	logic [2:0]   cl_ff;
	logic [2:0]   sl_ff;

	assign io_rdata = io_rdata_ff;
	assign timer_out = out_w;

	// Counting tick derived from the core clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else if (div_ff == 16'(TICK_DIV - 1)) begin
			div_ff <= 16'h0000;
			tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	// Software gate bit of system control port B
	always_ff @(posedge core_clk) begin
		if (reset) begin
			soft_gate_ff <= 1'b0;
		end else if (io_wr && io_addr == `PITCM_PORT_SYSB) begin
			soft_gate_ff <= io_wdata[`PITCM_SYSB_GATE];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			gate2_ff <= 1'b0;
		end else begin
			gate2_ff <= channel2_gate_pin | soft_gate_ff;
		end
	end

	// Command decode on the shared port
	assign wr_ctrl = io_wr && (io_addr == `PITCM_PORT_CTRL);
	always_comb begin
		cmd = cmd_none;
		if (!wr_ctrl) begin
			cmd = cmd_none;
		end else if (io_wdata[`PITCM_SEL_HI:`PITCM_SEL_LO] == `PITCM_SEL_RDBK) begin
			cmd = cmd_rdbk;
		end else if (io_wdata[`PITCM_RW_HI:`PITCM_RW_LO] == `PITCM_RW_LATCH) begin
			cmd = cmd_latch;
		end else begin
			cmd = cmd_mode;
		end
	end

	generate
		for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
			logic sel;
			logic last;
			pitcm_count_t src;

			assign sel = io_wdata[`PITCM_SEL_HI:`PITCM_SEL_LO] == 2'(i);
			assign mode_wr[i] = (cmd == cmd_mode) && sel;
			// Read-back may name several channels, a latch only one
			assign latch_req[i] = ((cmd == cmd_rdbk) && io_wdata[`PITCM_RB_SEL0 + i]
				&& !io_wdata[`PITCM_RB_LATCH_COUNT_N]) || ((cmd == cmd_latch) && sel);
			assign sta_req[i] = (cmd == cmd_rdbk) && io_wdata[`PITCM_RB_SEL0 + i]
				&& !io_wdata[`PITCM_RB_LATCH_STATUS_N];
			assign wr_cnt[i] = io_wr && (io_addr == `PITCM_PORT_COUNT0 + 16'(i));
			assign rd_cnt[i] = io_rd && (io_addr == `PITCM_PORT_COUNT0 + 16'(i));
			assign gate[i] = (i == 2) ? gate2_ff : 1'b1;

			// Count write assembly; single-byte widths clear the other half
			always_comb begin
				load[i] = 1'b0;
				load_val[i] = {8'h00, io_wdata};
				if (wr_cnt[i]) begin
					if (rw_ff[i] == `PITCM_RW_LSB) begin
						load[i] = 1'b1;
					end else if (rw_ff[i] == `PITCM_RW_MSB) begin
						load[i] = 1'b1;
						load_val[i] = {io_wdata, 8'h00};
					end else if (wr_hi_ff[i]) begin
						load[i] = 1'b1;
						load_val[i] = {io_wdata, wr_lo_ff[i]};
					end
				end
			end

			assign src = cl_ff[i] ? lat_ff[i] : cnt[i];
			assign last = (rw_ff[i] != `PITCM_RW_BOTH) || rd_hi_ff[i];
			always_comb begin
				if (sl_ff[i]) begin
					rd_byte[i] = sta_ff[i];
				end else if (rw_ff[i] == `PITCM_RW_MSB || (rw_ff[i] == `PITCM_RW_BOTH && rd_hi_ff[i])) begin
					rd_byte[i] = src[15:8];
				end else begin
					rd_byte[i] = src[7:0];
				end
			end

			// Programmed settings; the initial count is kept only inside the channel
			always_ff @(posedge core_clk) begin
				if (reset) begin
					rw_ff[i] <= `PITCM_RW_LSB;
					mode_ff[i] <= `PITCM_MODE0;
					bcd_ff[i] <= 1'b0;
				end else if (mode_wr[i]) begin
					rw_ff[i] <= io_wdata[`PITCM_RW_HI:`PITCM_RW_LO];
					mode_ff[i] <= io_wdata[`PITCM_MODE_HI:`PITCM_MODE_LO];
					bcd_ff[i] <= io_wdata[`PITCM_BCD_BIT];
				end
			end

			// Byte order of count writes and reads
			always_ff @(posedge core_clk) begin
				if (reset || mode_wr[i]) begin
					wr_hi_ff[i] <= 1'b0;
					rd_hi_ff[i] <= 1'b0;
					wr_lo_ff[i] <= 8'h00;
				end else begin
					if (wr_cnt[i] && rw_ff[i] == `PITCM_RW_BOTH) begin
						wr_hi_ff[i] <= !wr_hi_ff[i];
						wr_lo_ff[i] <= io_wdata;
					end
					if (rd_cnt[i] && !sl_ff[i] && rw_ff[i] == `PITCM_RW_BOTH) begin
						rd_hi_ff[i] <= !rd_hi_ff[i];
					end
				end
			end

			// Count snapshot; the counter itself is never touched
			always_ff @(posedge core_clk) begin
				if (reset || mode_wr[i]) begin
					cl_ff[i] <= 1'b0;
					lat_ff[i] <= `PITCM_CNT_RST;
				end else if (latch_req[i] && !cl_ff[i]) begin
					cl_ff[i] <= 1'b1;
					lat_ff[i] <= cnt[i];
				end else if (rd_cnt[i] && !sl_ff[i] && cl_ff[i] && last) begin
					cl_ff[i] <= 1'b0;
				end
			end

			// Status snapshot
			always_ff @(posedge core_clk) begin
				if (reset || mode_wr[i]) begin
					sl_ff[i] <= 1'b0;
					sta_ff[i] <= `PITCM_CMD_RST;
				end else if (sta_req[i] && !sl_ff[i]) begin
					sl_ff[i] <= 1'b1;
					sta_ff[i] <= {out_w[i], null_w[i], rw_ff[i], mode_ff[i], bcd_ff[i]};
				end else if (rd_cnt[i] && sl_ff[i]) begin
					sl_ff[i] <= 1'b0;
				end
			end

			pitcm_channel #(
				.HAS_GATE (i == 2)
			) u_channel (
				.core_clk (core_clk),
				.reset    (reset),
				.tick     (tick_ff),
				.gate     (gate[i]),
				.mode_wr  (mode_wr[i]),
				.mode_in  (io_wdata[`PITCM_MODE_HI:`PITCM_MODE_LO]),
				.bcd_in   (io_wdata[`PITCM_BCD_BIT]),
				.load     (load[i]),
				.load_val (load_val[i]),
				.count_ff (cnt[i]),
				.out_ff   (out_w[i]),
				.null_ff  (null_w[i])
			);
		end
	endgenerate

	// Read data; command port and unmapped addresses give a fixed byte
	always_ff @(posedge core_clk) begin
		if (reset) begin
			io_rdata_ff <= 8'h00;
		end else if (io_rd) begin
			if (io_addr == `PITCM_PORT_COUNT0) begin
				io_rdata_ff <= rd_byte[0];
			end else if (io_addr == `PITCM_PORT_COUNT1) begin
				io_rdata_ff <= rd_byte[1];
			end else if (io_addr == `PITCM_PORT_COUNT2) begin
				io_rdata_ff <= rd_byte[2];
			end else if (io_addr == `PITCM_PORT_CTRL) begin
				io_rdata_ff <= `PITCM_CTRL_RD_VAL;
			end else if (io_addr == `PITCM_PORT_SYSB) begin
				io_rdata_ff <= {2'h0, out_w[2], 4'h0, soft_gate_ff};
			end else begin
				io_rdata_ff <= 8'h00;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Strobes come with an idle cycle between them, so the first read follows two cycles later
	sequence rb_both_s;
		sta_req[0] && latch_req[0] && !sl_ff[0] && !cl_ff[0]
		##1 !wr_ctrl && !rd_cnt[0]
		##1 rd_cnt[0] && !wr_ctrl;
	endsequence

	ctrl_read_fixed_a: assert property (io_rd && io_addr == `PITCM_PORT_CTRL
		|=> io_rdata == `PITCM_CTRL_RD_VAL)
		else $error("command port read not fixed");
	latch_snap_a: assert property (latch_req[0] && !cl_ff[0] |=> cl_ff[0] && lat_ff[0] == $past(cnt[0]))
		else $error("latch did not capture count");
	latch_ignore_a: assert property (latch_req[1] && cl_ff[1] && !mode_wr[1] |=> $stable(lat_ff[1]))
		else $error("second latch overwrote snapshot");
	latch_one_ch_a: assert property ((cmd == cmd_latch) && io_wdata[7:6] == 2'h0 && !cl_ff[1]
		|=> !cl_ff[1])
		else $error("latch command touched wrong channel");
	status_first_a: assert property (rb_both_s |=> io_rdata == sta_ff[0] ##0 cl_ff[0])
		else $error("status byte not returned first");
	gate_tied_a: assert property (gate[0] && gate[1])
		else $error("channel 0 or 1 gate not high");
	gate2_follow_a: assert property (channel2_gate_pin && !wr_ctrl |=> gate[2])
		else $error("channel 2 gate ignores pin");
	lsb_read_a: assert property (rd_cnt[0] && !sl_ff[0] && cl_ff[0] && rw_ff[0] == `PITCM_RW_LSB
		|=> io_rdata == $past(lat_ff[0][7:0]) && !cl_ff[0])
		else $error("low-byte latched read wrong");
endmodule

// ==== bench/pitcm_host_model.sv ====
// Host model issuing I/O writes and reads toward the interval timer
`include "pitcm_map.svh"
module pitcm_host_model (
	// Clock
	input  wire logic        core_clk,
	// I/O cycles
	output logic [15:0]      io_addr,
	output logic             io_wr,
	output logic             io_rd,
	output logic [7:0]       io_wdata,
	input  wire logic [7:0]  io_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// Released lines show the inverse of the last value so a stale sample never matches
	task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
		@(negedge core_clk);
		io_addr = addr;
		io_wdata = data;
		io_wr = 1'b1;
		@(negedge core_clk);
		io_wr = 1'b0;
		io_addr = ~addr;
		io_wdata = ~data;
	endtask

	// One strobe is one read; the data is taken after the sampling edge
	task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
		@(negedge core_clk);
		io_addr = addr;
		io_rd = 1'b1;
		@(negedge core_clk);
		io_rd = 1'b0;
		io_addr = ~addr;
		data = io_rdata;
	endtask

	task automatic latch(input logic [1:0] ch);
		io_write(`PITCM_PORT_CTRL, {ch, 6'h00});
	endtask
endmodule

// ==== bench/pitcm_tb_top.sv ====
// Self-checking testbench for the interval timer command port and counting modes
`include "pitcm_map.svh"
module pitcm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          TDIV = 4;
	localparam logic [15:0] CTL  = `PITCM_PORT_CTRL;
	localparam logic [15:0] C0   = `PITCM_PORT_COUNT0;
	localparam logic [15:0] C1   = `PITCM_PORT_COUNT1;
	localparam logic [15:0] C2   = `PITCM_PORT_COUNT2;
	localparam logic [15:0] SYB  = `PITCM_PORT_SYSB;

	logic        core_clk;
	logic        reset;
	logic        channel2_gate_pin;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic [2:0]  timer_out;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n;
	int          lo;
	int          per;
	int          c1;
	int          c3;
	logic [7:0]  b;
	logic [15:0] v1;
	logic [15:0] v2;
	logic [7:0]  mctl [4] = '{8'h14, 8'h1c, 8'h16, 8'h1e};
	logic [7:0]  mcnt [4] = '{8'h03, 8'h03, 8'h04, 8'h04};
	logic [7:0]  mlow [4] = '{8'h04, 8'h04, 8'h08, 8'h08};
	logic [7:0]  mper [4] = '{8'h0c, 8'h0c, 8'h10, 8'h10};

	pitcm_top #(.CHANNELS(3), .TICK_DIV(TDIV)) dut (
		.core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .channel2_gate_pin(channel2_gate_pin), .timer_out(timer_out)
	);

	pitcm_host_model host (
		.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata)
	);

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	// Whole run needs under a thousand cycles; the ceiling of 20000 leaves ample margin
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			$display("mismatch at %0t: run timed out", $time);
			final_report();
		end
	end

	task automatic final_report();
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_ok(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// Bounded wait for an output level; cnt is the number of cycles spent
	task automatic wait_out(input int ch, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (timer_out[ch] !== lvl && cnt < lim) begin
			@(negedge core_clk);
			cnt++;
		end
		chk_ok(cnt < lim, "output level never reached");
	endtask

	task automatic measure(input int ch, output int low, output int period);
		int k;
		wait_out(ch, 1'b1, 200, k);
		wait_out(ch, 1'b0, 200, k);
		wait_out(ch, 1'b1, 200, low);
		wait_out(ch, 1'b0, 200, k);
		period = low + k;
	endtask

	task automatic rd16(input logic [1:0] ch, output logic [15:0] v);
		logic [7:0] l8;
		logic [7:0] h8;
		host.latch(ch);
		host.io_read(C0 + {14'h0000, ch}, l8);
		host.io_read(C0 + {14'h0000, ch}, h8);
		v = {h8, l8};
	endtask

	initial begin
		reset = 1'b1;
		channel2_gate_pin = 1'b0;
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		chk8({5'h00, timer_out}, 8'h07, "reset outputs");
		// Mode 0 on channel 0, low byte only
		host.io_write(CTL, 8'h10);
		@(negedge core_clk);
		chk8({7'h00, timer_out[0]}, 8'h00, "mode 0 start level");
		host.io_read(CTL, b);
		chk8(b, `PITCM_CTRL_RD_VAL, "command port read");
		host.io_write(C0, 8'h05);
		wait_out(0, 1'b1, 60, n);
		chk_ok(n >= 4 * TDIV, "mode 0 ended early");
		repeat (40) @(negedge core_clk);
		chk8({7'h00, timer_out[0]}, 8'h01, "mode 0 hold high");
		host.io_write(CTL, 8'h10);
		@(negedge core_clk);
		chk8({7'h00, timer_out[0]}, 8'h00, "mode rewrite restart");
		// Rate and square wave with their alias codes; gate pin low shows channel 0 ignores it
		for (int i = 0; i < 4; i++) begin
			host.io_write(CTL, mctl[i]);
			host.io_write(C0, mcnt[i]);
			measure(0, lo, per);
			chk8(8'(lo), mlow[i], "low width");
			chk8(8'(per), mper[i], "period");
		end
		// Latch of channel 0 alone; low byte only, so one read releases it
		host.latch(2'h0);
		host.io_read(C0, b);
		chk_ok(b >= 8'h01 && b <= 8'h04, "channel 0 latched low byte");
		// Snapshot holds while the counter keeps running, and a second latch is ignored until read out
		host.io_write(CTL, 8'h74);
		host.io_write(C1, 8'h00);
		host.io_write(C1, 8'h10);
		repeat (20) @(negedge core_clk);
		c1 = cyc;
		host.latch(2'h1);
		repeat (40) @(negedge core_clk);
		host.latch(2'h1);
		host.io_read(C1, b);
		v1[7:0] = b;
		host.io_read(C1, b);
		v1[15:8] = b;
		c3 = cyc;
		rd16(2'h1, v2);
		chk_ok(v1 < 16'h1000 && v1 > 16'h0f00, "snapshot range");
		chk_ok((v1 - v2) >= 16'((c3 - c1) / TDIV - 2) && (v1 - v2) <= 16'((c3 - c1) / TDIV + 2),
			"latched count moved");
		// High byte only access
		host.io_write(CTL, 8'h64);
		host.io_write(C1, 8'h20);
		repeat (20) @(negedge core_clk);
		host.latch(2'h1);
		host.io_read(C1, b);
		chk_ok(b === 8'h1f || b === 8'h20, "high byte only");
		// Decimal counting
		host.io_write(CTL, 8'h75);
		host.io_write(C1, 8'h00);
		host.io_write(C1, 8'h10);
		repeat (60) @(negedge core_clk);
		rd16(2'h1, v1);
		chk_ok(v1 < 16'h1000 && v1 >= 16'h0980 && v1[7:4] <= 4'h9 && v1[3:0] <= 4'h9, "decimal count");
		// Mode 4 strobe on channel 1
		host.io_write(CTL, 8'h58);
		@(negedge core_clk);
		chk8({7'h00, timer_out[1]}, 8'h01, "mode 4 start level");
		host.io_write(C1, 8'h03);
		wait_out(1, 1'b0, 60, n);
		wait_out(1, 1'b1, 20, lo);
		chk8(8'(lo), 8'(TDIV), "strobe width");
		// Mode 1 on channel 2, triggered by pin then by software bit
		host.io_write(CTL, 8'h92);
		host.io_write(C2, 8'h03);
		repeat (40) @(negedge core_clk);
		chk8({7'h00, timer_out[2]}, 8'h01, "one-shot idle");
		channel2_gate_pin = 1'b1;
		wait_out(2, 1'b0, 20, n);
		wait_out(2, 1'b1, 40, lo);
		chk_ok(lo >= 2 * TDIV && lo <= 4 * TDIV, "pin one-shot width");
		channel2_gate_pin = 1'b0;
		repeat (8) @(negedge core_clk);
		host.io_write(SYB, 8'h01);
		wait_out(2, 1'b0, 20, n);
		wait_out(2, 1'b1, 40, lo);
		chk_ok(lo >= 2 * TDIV && lo <= 4 * TDIV, "soft one-shot width");
		host.io_read(SYB, b);
		chk8(b & 8'h21, 8'h21, "soft gate and output bits");
		host.io_write(SYB, 8'h00);
		// Mode 5 waits for a gate rise
		host.io_write(CTL, 8'h9a);
		host.io_write(C2, 8'h03);
		repeat (40) @(negedge core_clk);
		chk8({7'h00, timer_out[2]}, 8'h01, "gated strobe idle");
		channel2_gate_pin = 1'b1;
		wait_out(2, 1'b0, 40, n);
		wait_out(2, 1'b1, 20, lo);
		chk8(8'(lo), 8'(TDIV), "gated strobe width");
		channel2_gate_pin = 1'b0;
		// One read-back latches status of all three channels
		host.io_write(CTL, 8'hee);
		host.io_read(C0, b);
		chk8(b & 8'h7f, 8'h1e, "status ch0");
		host.io_read(C1, b);
		chk8(b, 8'h98, "status ch1");
		host.io_read(C2, b);
		chk8(b, 8'h9a, "status ch2");
		// Status comes before the count byte
		host.io_write(CTL, 8'hc2);
		host.io_read(C0, b);
		chk8(b & 8'h7f, 8'h1e, "status first");
		host.io_read(C0, b);
		chk_ok(b <= 8'h04, "count after status");
		final_report();
	end
endmodule
